//--- ais_pkg.sv
// Package: register map, field layout, timing counts and carriers for the A/D input sequencer
package ais_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] AIS_OFF_CTRL0   = 8'h00;
   localparam logic [7:0] AIS_OFF_CTRL1   = 8'h04;
   localparam logic [7:0] AIS_OFF_INSEL   = 8'h08;
   localparam logic [7:0] AIS_OFF_PA_FS   = 8'h0C;
   localparam logic [7:0] AIS_OFF_PB_FS   = 8'h10;
   localparam logic [7:0] AIS_OFF_PULL    = 8'h14;
   localparam logic [7:0] AIS_OFF_DIR     = 8'h18;
   localparam logic [7:0] AIS_OFF_RES_HI  = 8'h1C;
   localparam logic [7:0] AIS_OFF_RES_LO  = 8'h20;
   localparam logic [7:0] AIS_OFF_STATUS  = 8'h24;
   localparam logic [7:0] AIS_OFF_MASK    = 8'h28;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int AIS_C0_PWR   = 0;
   localparam int AIS_C0_RFS   = 1;
   localparam int AIS_C0_START = 2;
   localparam int AIS_C0_BUSY  = 3;
   localparam int AIS_C0_CIE   = 4;
   localparam int AIS_C0_GIE   = 5;
   localparam int AIS_C1_CKS   = 0;
   localparam int AIS_C1_REF   = 4;
   localparam int AIS_IS_CHAN  = 0;
   localparam int AIS_IS_SRC   = 4;

   // ----------------------------------------------------------------
   // Codes and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0]  AIS_SRC_EXT0    = 3'h0;
   localparam logic [2:0]  AIS_SRC_BANDGAP = 3'h1;
   localparam logic [2:0]  AIS_SRC_TEMP    = 3'h2;
   localparam logic [2:0]  AIS_SRC_OPOUT   = 3'h3;
   localparam logic [2:0]  AIS_SRC_OPPOS   = 3'h4;
   localparam logic [2:0]  AIS_SRC_EXT5    = 3'h5;
   localparam logic [2:0]  AIS_SRC_EXT6    = 3'h6;
   localparam logic [1:0]  AIS_FS_ANALOG   = 2'h3;
   localparam logic [1:0]  AIS_REF_EXT_LDO = 2'h0;
   localparam logic [1:0]  AIS_REF_TSREF   = 2'h2;
   localparam logic [3:0]  AIS_CHAN_RST    = 4'hF;
   localparam logic [1:0]  AIS_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  AIS_RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Phase lengths in A/D clock periods
   // ----------------------------------------------------------------
   localparam logic [5:0]  AIS_SAMPLE_STD  = 6'h04;
   localparam logic [5:0]  AIS_SAMPLE_TEMP = 6'h2E;
   localparam logic [3:0]  AIS_CONV_BITS   = 4'hC;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {AIS_IDLE, AIS_SAMPLE, AIS_CONVERT} ais_seq_t;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } ais_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } ais_axi_rsp_t;

   typedef struct packed {
      logic        power_en;
      logic        sampling;
      logic        converting;
      logic [7:0]  pin_connect;
      logic [3:0]  internal_sel;
      logic [2:0]  ref_sel_onehot;
      logic [11:0] sar_trial;
   } ais_analog_t;

   typedef struct packed {
      logic [7:0]  analog_en;
      logic [7:0]  digital_en;
      logic [7:0]  output_en;
      logic [7:0]  pullup_en;
   } ais_pins_t;

endpackage

//--- ais_adc_ctrl.sv
// A/D input selection, pin override, sample/convert sequencer and AXI4-Lite registers
`timescale 1ns/1ps

// Notes on behaviour
// - Analog-selected pin loses other functions and its direction setting.
// - Pull-high on a pin drops whenever that pin is analog.
// - Sources 000/101/110 pick external pin zero to seven by channel code.
// - External source with channel 1000..1111 connects no pin.
// - Sources 001..100 route bandgap, temperature, op-amp out, op-amp plus.
// - Non-temperature conversion: 4 sample plus 12 convert periods.
// - Temperature conversion: 46 sample plus 12 convert, 58 periods.
// - A low-high-low start pulse begins sampling.
// - Busy high during conversion, falls with valid result registers.
// - A/D clock is system clock divided per three-bit select.
// - Format bit aligns the 12-bit result across high and low bytes.
// - Two-bit reference select picks the converter reference source.
// - Reference code 00 pin/regulator, 01/11 supply, 10 sensor reference.
// - Result is 12-bit unsigned, all ones at full scale.
module ais_adc_ctrl
(
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   // Register bus
   input  wire ais_pkg::ais_axi_req_t axi_req,
   output      ais_pkg::ais_axi_rsp_t axi_rsp,
   // Analog core
   input  wire logic                  cmp_in,
   output      ais_pkg::ais_analog_t  analog,
   // Shared pins
   output      ais_pkg::ais_pins_t    pins,
   // Interrupt
   output      logic                  irq
);
   import ais_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        aw_held;
      logic [7:0]  aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        pwr;
      logic        rfs;
      logic        start;
      logic        start_armed;
      logic        cie;
      logic        gie;
      logic [2:0]  clk_sel;
      logic [1:0]  ref_sel;
      logic [3:0]  chan;
      logic [2:0]  src;
      logic [7:0]  pa_fs;
      logic [7:0]  pb_fs;
      logic [7:0]  pull;
      logic [7:0]  dir;
      logic [7:0]  res_hi;
      logic [7:0]  res_lo;
      logic        done_st;
      logic        done_mask;
      ais_seq_t    seq;
      logic [6:0]  div_cnt;
      logic [5:0]  ph_cnt;
      logic [3:0]  bit_idx;
      logic [11:0] sar;
      logic        temp_conv;
   } ais_state_t;

   ais_state_t  st;
   ais_state_t  next_st;

   logic        ext_src;
   logic [7:0]  pin_analog;
   logic [6:0]  div_lim;
   logic        adck_tick;
   logic        do_write;
   logic        ar_take;
   logic        done_evt;
   logic        launch;
   logic [5:0]  sample_last;
   logic [31:0] rd_word;
   logic        rd_hit;

   // ----------------------------------------------------------------
   // Decode of selections
   // ----------------------------------------------------------------
   // External path on the three external codes
   assign ext_src = (st.src == AIS_SRC_EXT0) || (st.src == AIS_SRC_EXT5)
                    || (st.src == AIS_SRC_EXT6);

   // Per-pin function override, pull-high and channel connect
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_pin
         if (gi < 4)
         begin : g_pa
            assign pin_analog[gi] = (st.pa_fs[2*gi +: 2] == AIS_FS_ANALOG);
         end
         else
         begin : g_pb
            assign pin_analog[gi] = (st.pb_fs[2*(gi-4) +: 2] == AIS_FS_ANALOG);
         end
         assign pins.analog_en[gi]  = pin_analog[gi];
         assign pins.digital_en[gi] = ~pin_analog[gi];
         assign pins.output_en[gi]  = st.dir[gi] & ~pin_analog[gi];
         assign pins.pullup_en[gi]  = st.pull[gi] & ~pin_analog[gi];
         // Channel codes 8..15 match no pin, leaving the input floating
         assign analog.pin_connect[gi] = ext_src
                                         && (st.chan == 4'(gi));
      end
   endgenerate

   // Internal signal routing, one-hot in source order
   assign analog.internal_sel[0] = (st.src == AIS_SRC_BANDGAP);
   assign analog.internal_sel[1] = (st.src == AIS_SRC_TEMP);
   assign analog.internal_sel[2] = (st.src == AIS_SRC_OPOUT);
   assign analog.internal_sel[3] = (st.src == AIS_SRC_OPPOS);

   // Reference choice: bit0 pin/regulator, bit1 supply, bit2 sensor ref
   assign analog.ref_sel_onehot[0] = (st.ref_sel == AIS_REF_EXT_LDO);
   assign analog.ref_sel_onehot[2] = (st.ref_sel == AIS_REF_TSREF);
   assign analog.ref_sel_onehot[1] = st.ref_sel[0];

   // Converter status towards the analog core
   assign analog.power_en   = st.pwr;
   assign analog.sampling   = (st.seq == AIS_SAMPLE);
   assign analog.converting = (st.seq == AIS_CONVERT);
   assign analog.sar_trial  = st.sar | (12'h001 << st.bit_idx);

   // ----------------------------------------------------------------
   // A/D clock divider and sequencing terms
   // ----------------------------------------------------------------
   assign div_lim     = 7'((8'h01 << st.clk_sel) - 8'h01);
   assign adck_tick   = (st.div_cnt == div_lim);
   assign sample_last = (st.temp_conv ? AIS_SAMPLE_TEMP
                                      : AIS_SAMPLE_STD) - 6'h01;
   assign launch      = st.start_armed && !st.start && st.pwr
                        && (st.seq == AIS_IDLE);
   assign done_evt    = (st.seq == AIS_CONVERT) && adck_tick
                        && (st.bit_idx == 4'h0);

   // ----------------------------------------------------------------
   // Bus handshake terms and read mux
   // ----------------------------------------------------------------
   assign do_write = st.aw_held && st.w_held && !st.bvalid;
   assign ar_take  = axi_req.arvalid && !st.rvalid;

   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (axi_req.araddr)
         AIS_OFF_CTRL0:
         begin
            rd_word[AIS_C0_PWR]   = st.pwr;
            rd_word[AIS_C0_RFS]   = st.rfs;
            rd_word[AIS_C0_START] = st.start;
            rd_word[AIS_C0_BUSY]  = (st.seq != AIS_IDLE);
            rd_word[AIS_C0_CIE]   = st.cie;
            rd_word[AIS_C0_GIE]   = st.gie;
         end
         AIS_OFF_CTRL1:
         begin
            rd_word[AIS_C1_CKS +: 3] = st.clk_sel;
            rd_word[AIS_C1_REF +: 2] = st.ref_sel;
         end
         AIS_OFF_INSEL:
         begin
            rd_word[AIS_IS_CHAN +: 4] = st.chan;
            rd_word[AIS_IS_SRC +: 3]  = st.src;
         end
         AIS_OFF_PA_FS:  rd_word[7:0] = st.pa_fs;
         AIS_OFF_PB_FS:  rd_word[7:0] = st.pb_fs;
         AIS_OFF_PULL:   rd_word[7:0] = st.pull;
         AIS_OFF_DIR:    rd_word[7:0] = st.dir;
         AIS_OFF_RES_HI: rd_word[7:0] = st.res_hi;
         AIS_OFF_RES_LO: rd_word[7:0] = st.res_lo;
         AIS_OFF_STATUS: rd_word[0]   = st.done_st;
         AIS_OFF_MASK:   rd_word[0]   = st.done_mask;
         default:        rd_hit       = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st = st;

      // Address and data channels taken in either order
      if (axi_req.awvalid && !st.aw_held)
      begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !st.w_held)
      begin
         next_st.w_held = 1'b1;
         next_st.w_data = axi_req.wdata;
         next_st.w_strb = axi_req.wstrb;
      end
      if (st.bvalid && axi_req.bready)
      begin
         next_st.bvalid = 1'b0;
      end

      // Register write, low byte lane only
      if (do_write)
      begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = AIS_RESP_OKAY;
         if (st.w_strb[0])
         begin
            case (st.aw_addr)
               AIS_OFF_CTRL0:
               begin
                  next_st.pwr   = st.w_data[AIS_C0_PWR];
                  next_st.rfs   = st.w_data[AIS_C0_RFS];
                  next_st.start = st.w_data[AIS_C0_START];
                  next_st.cie   = st.w_data[AIS_C0_CIE];
                  next_st.gie   = st.w_data[AIS_C0_GIE];
               end
               AIS_OFF_CTRL1:
               begin
                  next_st.clk_sel = st.w_data[AIS_C1_CKS +: 3];
                  next_st.ref_sel = st.w_data[AIS_C1_REF +: 2];
               end
               AIS_OFF_INSEL:
               begin
                  next_st.chan = st.w_data[AIS_IS_CHAN +: 4];
                  next_st.src  = st.w_data[AIS_IS_SRC +: 3];
               end
               AIS_OFF_PA_FS: next_st.pa_fs     = st.w_data[7:0];
               AIS_OFF_PB_FS: next_st.pb_fs     = st.w_data[7:0];
               AIS_OFF_PULL:  next_st.pull      = st.w_data[7:0];
               AIS_OFF_DIR:   next_st.dir       = st.w_data[7:0];
               AIS_OFF_MASK:  next_st.done_mask = st.w_data[0];
               AIS_OFF_RES_HI, AIS_OFF_RES_LO, AIS_OFF_STATUS: ;
               default:       next_st.bresp     = AIS_RESP_SLVERR;
            endcase
         end
         else if (!(st.aw_addr inside {AIS_OFF_CTRL0, AIS_OFF_CTRL1, AIS_OFF_INSEL,
                  AIS_OFF_PA_FS, AIS_OFF_PB_FS, AIS_OFF_PULL, AIS_OFF_DIR,
                  AIS_OFF_RES_HI, AIS_OFF_RES_LO, AIS_OFF_STATUS, AIS_OFF_MASK}))
         begin
            next_st.bresp = AIS_RESP_SLVERR;
         end
      end

      // Read channel; a status read clears the sticky bit
      if (st.rvalid && axi_req.rready)
      begin
         next_st.rvalid = 1'b0;
      end
      if (ar_take)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = rd_word;
         next_st.rresp  = rd_hit ? AIS_RESP_OKAY : AIS_RESP_SLVERR;
         if (axi_req.araddr == AIS_OFF_STATUS)
         begin
            next_st.done_st = 1'b0;
         end
      end

      // Start pulse: arm on high, fire on return to low
      if (st.start)
      begin
         next_st.start_armed = 1'b1;
      end
      else if (st.start_armed)
      begin
         next_st.start_armed = 1'b0;
      end

      // A/D clock divider, realigned at launch
      next_st.div_cnt = adck_tick ? 7'h00 : st.div_cnt + 7'h01;

      // Sample and convert sequencer
      case (st.seq)
         AIS_IDLE:
         begin
            if (launch)
            begin
               next_st.seq       = AIS_SAMPLE;
               next_st.div_cnt   = 7'h00;
               next_st.ph_cnt    = 6'h00;
               next_st.temp_conv = (st.src == AIS_SRC_TEMP);
               next_st.sar       = 12'h000;
               next_st.bit_idx   = AIS_CONV_BITS - 4'h1;
            end
         end
         AIS_SAMPLE:
         begin
            if (adck_tick)
            begin
               if (st.ph_cnt == sample_last)
               begin
                  next_st.seq = AIS_CONVERT;
               end
               else
               begin
                  next_st.ph_cnt = st.ph_cnt + 6'h01;
               end
            end
         end
         AIS_CONVERT:
         begin
            // One result bit decided per A/D clock period, MSB first
            if (adck_tick)
            begin
               next_st.sar[st.bit_idx] = cmp_in;
               next_st.bit_idx = st.bit_idx - 4'h1;
               if (st.bit_idx == 4'h0)
               begin
                  next_st.seq = AIS_IDLE;
                  if (st.rfs)
                  begin
                     next_st.res_hi = {4'h0, st.sar[11:8]};
                     next_st.res_lo = {st.sar[7:1], cmp_in};
                  end
                  else
                  begin
                     next_st.res_hi = st.sar[11:4];
                     next_st.res_lo = {st.sar[3:1], cmp_in, 4'h0};
                  end
               end
            end
         end
         default: next_st.seq = AIS_IDLE;
      endcase

      // Powering down aborts any conversion in flight, at the same edge
      if (!next_st.pwr)
      begin
         next_st.seq = AIS_IDLE;
      end

      // Completion sets the sticky bit; set wins over a clearing read
      if (done_evt && next_st.pwr)
      begin
         next_st.done_st = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         st         <= '0;
         st.chan    <= AIS_CHAN_RST;
         st.seq     <= AIS_IDLE;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign axi_rsp.awready = !st.aw_held;
   assign axi_rsp.wready  = !st.w_held;
   assign axi_rsp.bvalid  = st.bvalid;
   assign axi_rsp.bresp   = st.bresp;
   assign axi_rsp.arready = !st.rvalid;
   assign axi_rsp.rvalid  = st.rvalid;
   assign axi_rsp.rdata   = st.rdata;
   assign axi_rsp.rresp   = st.rresp;

   // Interrupt reaches the CPU only with status, mask bit and both enables set
   assign irq = st.done_st && st.done_mask && st.cie && st.gie;

endmodule // ais_adc_ctrl

//--- ais_adc_checker.sv
// Port-level assertions for the A/D input sequencer
`timescale 1ns/1ps
module ais_adc_checker
(
   // Clock, reset and buses
   input wire logic                  ref_clk,
   input wire logic                  rst_n,
   input wire ais_pkg::ais_axi_req_t axi_req,
   input wire ais_pkg::ais_axi_rsp_t axi_rsp,
   // Analog core, pins, interrupt
   input wire logic                  cmp_in,
   input wire ais_pkg::ais_analog_t  analog,
   input wire ais_pkg::ais_pins_t    pins,
   input wire logic                  irq
);
   import ais_pkg::*;
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Convert phase opens only out of sampling
   sequence s_conv_begin;
      $rose(analog.converting);
   endsequence
   chk_pin_override: assert property ((pins.output_en & pins.analog_en) == 8'h00
      && pins.digital_en == ~pins.analog_en) else $error("Analog pin keeps digital use");
   chk_pull_drop: assert property ((pins.pullup_en & pins.analog_en) == 8'h00)
      else $error("Pull-high left on analog pin");
   chk_one_pin: assert property ($onehot0(analog.pin_connect))
      else $error("Several pins on converter");
   chk_no_short: assert property ((analog.pin_connect != 8'h00) |-> analog.internal_sel == 4'h0)
      else $error("Pin and internal signal both routed");
   chk_int_onehot: assert property ($onehot0(analog.internal_sel))
      else $error("Several internal signals routed");
   chk_ref_onehot: assert property ($onehot(analog.ref_sel_onehot))
      else $error("Reference choice not single");
   chk_phase_excl: assert property (!(analog.sampling && analog.converting))
      else $error("Sample and convert overlap");
   chk_conv_order: assert property (s_conv_begin |-> $past(analog.sampling))
      else $error("Convert began without sampling");
   chk_conv_power: assert property (analog.converting |-> analog.power_en)
      else $error("Converting while unpowered");
   chk_b_hold: assert property (axi_rsp.bvalid && !axi_req.bready
      |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("Write response dropped");
   chk_r_hold: assert property (axi_rsp.rvalid && !axi_req.rready
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("Read response dropped");
   chk_ar_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("Read not answered in one cycle");
endmodule // ais_adc_checker

bind ais_adc_ctrl ais_adc_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .axi_req(axi_req),
   .axi_rsp(axi_rsp), .cmp_in(cmp_in), .analog(analog), .pins(pins), .irq(irq));

//--- ais_analog_model.sv
// Behavioural analog core answering the SAR comparator
`timescale 1ns/1ps
module ais_analog_model
(
   // Clock and core control
   input  wire logic                 ref_clk,
   input  wire ais_pkg::ais_analog_t analog,
   // Levels on pins and internal signals
   input  wire logic [11:0]          pin_level,
   input  wire logic [11:0]          int_level,
   // Comparator
   output      logic                 cmp_in
);
   import ais_pkg::*;
   // ----------------------------------------------------------------
   // Comparator
   // ----------------------------------------------------------------
   logic        noise = 1'b0;
   logic [11:0] level;
   // Floating input wanders so no value is implied
   always @(posedge ref_clk) noise <= ~noise;
   // Routed source level: pin when a pin connects, else internal
   always_comb level = (|analog.pin_connect) ? pin_level : int_level;
   // Compare only while converting with something routed
   assign cmp_in = (analog.converting && ((|analog.pin_connect) || (|analog.internal_sel)))
      ? (level >= analog.sar_trial) : noise;
endmodule // ais_analog_model

//--- tb_ais_adc_ctrl.sv
// Register-level testbench for the A/D input sequencer
`timescale 1ns/1ps
module tb_ais_adc_ctrl;
   import ais_pkg::*;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic         ref_clk = 1'b0;
   logic         rst_n = 1'b0;
   ais_axi_req_t axi_req = '0;
   ais_axi_rsp_t axi_rsp;
   ais_analog_t  analog;
   ais_pins_t    pins;
   logic         irq;
   logic         cmp_in;
   logic [11:0]  pin_level = 12'h000;
   logic [11:0]  int_level = 12'h000;
   logic [31:0]  rd;
   logic [1:0]   rsp;
   logic [2:0]   ext_src [3] = '{AIS_SRC_EXT0, AIS_SRC_EXT5, AIS_SRC_EXT6};
   int           fail_count = 0;
   int           check_count = 0;
   int           n_samp = 0;
   int           n_conv = 0;

   ais_adc_ctrl u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
      .cmp_in(cmp_in), .analog(analog), .pins(pins), .irq(irq));
   ais_analog_model u_core (.ref_clk(ref_clk), .analog(analog), .pin_level(pin_level),
      .int_level(int_level), .cmp_in(cmp_in));

   // Free-running clock
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   // Phase length counters
   always @(posedge ref_clk)
   begin
      if (analog.sampling) n_samp++;
      if (analog.converting) n_conv++;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_p;
      logic w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hF;
      axi_req.bready <= 1'b1;
      // Ready stays high; only the watchdog ends a hang
      do
      begin
         @(posedge ref_clk);
         if (aw_p && axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
         if (aw_p && axi_rsp.awready === 1'b1) aw_p = 1'b0;
         if (w_p && axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
         if (w_p && axi_rsp.wready === 1'b1) w_p = 1'b0;
         r = axi_rsp.bresp;
      end
      while (axi_rsp.bvalid !== 1'b1);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      axi_req.arvalid <= 1'b1;
      axi_req.araddr <= a;
      axi_req.rready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
         d = axi_rsp.rdata;
         r = axi_rsp.rresp;
      end
      while (axi_rsp.rvalid !== 1'b1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi_wr(a, d, rsp);
      chk("bresp", AIS_RESP_OKAY, rsp);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      axi_rd(a, rd, rsp);
      chk(name, exp, rd);
   endtask

   // One conversion from setup to result, status and interrupt
   task automatic conv(input logic [2:0] src, input logic [3:0] ch, input logic [2:0] cks,
                       input logic rfs, input logic [11:0] lvl, input logic msk);
      int          s;
      logic [31:0] c0;
      s = (src == AIS_SRC_TEMP) ? 46 : 4;
      c0 = 32'h0000_0031 | (32'(rfs) << AIS_C0_RFS);
      pin_level <= (src == AIS_SRC_TEMP) ? ~lvl : lvl;
      int_level <= (src == AIS_SRC_TEMP) ? lvl : ~lvl;
      wr(AIS_OFF_INSEL, {25'h0, src, ch});
      wr(AIS_OFF_CTRL1, {29'h0, cks});
      wr(AIS_OFF_CTRL0, c0);
      wr(AIS_OFF_MASK, {31'h0, msk});
      n_samp = 0;
      n_conv = 0;
      wr(AIS_OFF_CTRL0, c0 | 32'h0000_0004);
      wr(AIS_OFF_CTRL0, c0);
      rd_chk("busy high", AIS_OFF_CTRL0, c0 | 32'h0000_0008);
      chk("power en", 32'h1, {31'h0, analog.power_en});
      do
         axi_rd(AIS_OFF_CTRL0, rd, rsp);
      while (rd[AIS_C0_BUSY] !== 1'b0);
      chk("sample periods", s << cks, n_samp);
      chk("convert periods", 12 << cks, n_conv);
      chk("irq", {31'h0, msk}, {31'h0, irq});
      rd_chk("result hi", AIS_OFF_RES_HI, rfs ? {28'h0, lvl[11:8]} : {24'h0, lvl[11:4]});
      rd_chk("result lo", AIS_OFF_RES_LO, rfs ? {24'h0, lvl[7:0]} : {24'h0, lvl[3:0], 4'h0});
      rd_chk("status", AIS_OFF_STATUS, 32'h0000_0001);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd_chk("status clear", AIS_OFF_STATUS, 32'h0);
      $display("Test conversion source %0d done", src);
   endtask

   // Verdict and end of run
   task automatic test_done;
      $display("Checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   // Watchdog against a hung handshake
   initial
   begin
      #100_000;
      fail_count++;
      test_done;
   end
   // Main sequence
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd_chk("insel reset", AIS_OFF_INSEL, {28'h0, AIS_CHAN_RST});
      rd_chk("ctrl0 reset", AIS_OFF_CTRL0, 32'h0);
      axi_rd(8'h2C, rd, rsp);
      chk("unmapped rresp", AIS_RESP_SLVERR, rsp);
      axi_wr(8'h2C, 32'h0000_0001, rsp);
      chk("unmapped bresp", AIS_RESP_SLVERR, rsp);
      wr(AIS_OFF_RES_HI, 32'h0000_00FF);
      rd_chk("result read only", AIS_OFF_RES_HI, 32'h0);
      $display("Test registers done");
      wr(AIS_OFF_DIR, 32'h0000_00FF);
      wr(AIS_OFF_PULL, 32'h0000_00FF);
      wr(AIS_OFF_PA_FS, 32'h0000_00FF);
      wr(AIS_OFF_PB_FS, 32'h0000_0003);
      chk("analog en", 32'h1F, {24'h0, pins.analog_en});
      chk("digital en", 32'hE0, {24'h0, pins.digital_en});
      chk("output en", 32'hE0, {24'h0, pins.output_en});
      chk("pull en", 32'hE0, {24'h0, pins.pullup_en});
      $display("Test pin override done");
      foreach (ext_src[k])
         for (int c = 0; c < 16; c++)
         begin
            wr(AIS_OFF_INSEL, {25'h0, ext_src[k], 4'(c)});
            chk("pin connect", (c < 8) ? (1 << c) : 0, {24'h0, analog.pin_connect});
         end
      for (int s = 1; s < 5; s++)
      begin
         wr(AIS_OFF_INSEL, {25'h0, 3'(s), 4'hF});
         chk("internal sel", 1 << (s - 1), {28'h0, analog.internal_sel});
      end
      for (int r = 0; r < 4; r++)
      begin
         wr(AIS_OFF_CTRL1, 32'(r) << AIS_C1_REF);
         chk("reference", (r == 0) ? 1 : (r == 2) ? 4 : 2, {29'h0, analog.ref_sel_onehot});
      end
      $display("Test routing done");
      conv(AIS_SRC_EXT0, 4'h2, 3'h0, 1'b0, 12'hFFF, 1'b1);
      conv(AIS_SRC_TEMP, 4'hF, 3'h1, 1'b1, 12'hA5C, 1'b0);
      conv(AIS_SRC_EXT5, 4'h7, 3'h7, 1'b0, 12'h3C9, 1'b1);
      test_done;
   end
endmodule // tb_ais_adc_ctrl
